// ==== hdl/mcp_clipper_path.sv ====
/*
 Multiband clipper path: common drive, bass/mid/high band clippers with
 their post filters, hard or look-ahead soft bass, and the oversampled
 final clipper with finesse and overshoot controls.
 Assumes sampleValid pulses once per audio sample and the six band
 inputs hold beside it; operator settings come over the register port.
*/
`timescale 1ns/1ps
`include "mcp_regs.svh"
// Functional notes
// (RQ1) Mixer pairs six bands, trims within 3dB
// (RQ2) Bands 1+2 bass, 3+4 mid, 5+6 high
// (RQ3) Low, band, high pass after each clipper
// (RQ4) One common drive gain, unity is 0dB
// (RQ5) Thresholds relative to final clip level
// (RQ6) Each band output hard-limited to threshold; soft bass is clamped to the ceiling instead
// (RQ7) Operator keeps mid/high thresholds -8..-3dB
// (RQ8) Hard bass clips at bass threshold
// (RQ9) Soft bass uses delayed look-ahead gain limiter
// (RQ10) Soft bass rises to full scale alone
// (RQ11) Mid/high lower bass ceiling, not below threshold
// (RQ12) Oversampled final clipper, drive, embedded low-pass
// (RQ13) Finesse limits bass pushing highs, restricted range
// (RQ14) Overshoot control raises final clip level
// (RQ15) Ceiling is full scale minus mid/high peak
module mcp_clipper_path #(
   parameter int W  = 24,
   parameter int LA = 16
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                sys_rst,
   // Register port
   input  wire logic [7:0]          regAddr,
   input  wire logic [31:0]         regWdata,
   input  wire logic                regWr,
   input  wire logic                regRd,
   output logic      [31:0]         regRdata,
   // Band inputs from the mixer
   input  wire logic                sampleValid,
   input  wire logic signed [W-1:0] band1,
   input  wire logic signed [W-1:0] band2,
   input  wire logic signed [W-1:0] band3,
   input  wire logic signed [W-1:0] band4,
   input  wire logic signed [W-1:0] band5,
   input  wire logic signed [W-1:0] band6,
   // Final clipper output
   output logic                     outValid,
   output logic signed [W:0]        finalOut
);
   import mcp_pkg::*;

   localparam int IW = W + 2;
   localparam logic signed [IW+16:0] PMAX  = (IW+17)'((1 << (IW-1)) - 1);
   localparam logic signed [IW-1:0]  IMAX  = IW'((1 << (IW-1)) - 1);
   localparam logic signed [IW-1:0]  FSAMP = IW'((1 << (W-1)) - 1);

   // Gain multiply with shift and saturation
   function automatic logic signed [IW-1:0] mulSat(input logic signed [IW-1:0] x,
                                                   input mcp_gain_t g, input int sh);
      logic signed [IW+16:0] p;
      p = (IW+17)'(x) * $signed({1'b0, g});
      p = p >>> sh;
      if (p > PMAX) mulSat = IMAX;
      else if (p < -PMAX) mulSat = -IMAX;
      else mulSat = p[IW-1:0];
   endfunction

   // Symmetric clamp to plus or minus a positive limit
   function automatic logic signed [IW-1:0] clampSym(input logic signed [IW-1:0] x,
                                                     input logic signed [IW-1:0] lim);
      if (x > lim) clampSym = lim;
      else if (x < -lim) clampSym = -lim;
      else clampSym = x;
   endfunction

   function automatic logic signed [IW-1:0] absv(input logic signed [IW-1:0] x);
      absv = (x < 0) ? -x : x;
   endfunction

   // Threshold word as a fraction of the final clip level
   function automatic logic signed [IW-1:0] thrAmp(input mcp_gain_t t);
      thrAmp = $signed(IW'(t) << (W-16)); // [RQ5]
   endfunction

   // Operator settings and read data
   mcp_bass_e             mode_r, mode_nxt;
   mcp_gain_t             drive_r, drive_nxt;
   mcp_gain_t             bassThr_r, bassThr_nxt;
   mcp_gain_t             midThr_r, midThr_nxt;
   mcp_gain_t             hfThr_r, hfThr_nxt;
   mcp_gain_t             fdrive_r, fdrive_nxt;
   logic [`MCP_FINESSE_W-1:0] finesse_r, finesse_nxt;
   logic [`MCP_OVS_W-1:0] ovs_r, ovs_nxt;
   logic [31:0]           rdata_r, rdata_nxt;

   // Pipeline state
   logic                  s1V_r, s2V_r, s3V_r, outV_r;
   logic signed [IW-1:0]  bassIn_r, bassIn_nxt;
   logic signed [IW-1:0]  midIn_r, midIn_nxt;
   logic signed [IW-1:0]  hfIn_r, hfIn_nxt;
   logic signed [IW-1:0]  bassC_r, bassC_nxt;
   logic signed [IW-1:0]  midC_r, midC_nxt;
   logic signed [IW-1:0]  hfC_r, hfC_nxt;
   logic signed [IW-1:0]  ceil_r, ceil_nxt;
   mcp_gain_t             gain_r, gain_nxt;
   logic signed [IW-1:0]  prev_r, prev_nxt;
   logic signed [IW-1:0]  lp_r, lp_nxt;
   logic signed [W:0]     final_r, final_nxt;

   // Look-ahead delay lines, tap 0 is the incoming sample
   logic signed [IW-1:0]  bassLine_r [LA];
   logic signed [IW-1:0]  midLine_r  [LA];
   logic signed [IW-1:0]  hfLine_r   [LA];
   logic signed [IW-1:0]  bassTap    [LA+1];
   logic signed [IW-1:0]  midTap     [LA+1];
   logic signed [IW-1:0]  hfTap      [LA+1];

   // Filtered band outputs
   logic signed [IW-1:0]  bassF, midF, hfF;

   // Register port decode, settings steer the path
   always_comb begin
      mode_nxt    = mode_r;
      drive_nxt   = drive_r;
      bassThr_nxt = bassThr_r;
      midThr_nxt  = midThr_r;
      hfThr_nxt   = hfThr_r;
      fdrive_nxt  = fdrive_r;
      finesse_nxt = finesse_r;
      ovs_nxt     = ovs_r;
      rdata_nxt   = 32'h0000_0000;
      if (regWr) begin
         case (regAddr)
            `MCP_ADDR_CTRL:     mode_nxt = mcp_bass_e'(regWdata[`MCP_CTRL_SOFT_BIT]);
            `MCP_ADDR_DRIVE:    drive_nxt = regWdata[15:0];
            `MCP_ADDR_BASS_THR: bassThr_nxt = regWdata[15] ? `MCP_THR_MAX : regWdata[15:0];
            `MCP_ADDR_MID_THR:  midThr_nxt = regWdata[15] ? `MCP_THR_MAX : regWdata[15:0];
            `MCP_ADDR_HF_THR:   hfThr_nxt = regWdata[15] ? `MCP_THR_MAX : regWdata[15:0];
            `MCP_ADDR_FDRIVE:   fdrive_nxt = regWdata[15:0];
            `MCP_ADDR_FINESSE:  finesse_nxt = regWdata[`MCP_FINESSE_W-1:0]; // [RQ13]
            `MCP_ADDR_OVS:      ovs_nxt = regWdata[`MCP_OVS_W-1:0];
            default:            ;
         endcase
      end
      if (regRd) begin
         case (regAddr)
            `MCP_ADDR_CTRL:     rdata_nxt = {31'h0, mode_r};
            `MCP_ADDR_DRIVE:    rdata_nxt = {16'h0, drive_r};
            `MCP_ADDR_BASS_THR: rdata_nxt = {16'h0, bassThr_r};
            `MCP_ADDR_MID_THR:  rdata_nxt = {16'h0, midThr_r};
            `MCP_ADDR_HF_THR:   rdata_nxt = {16'h0, hfThr_r};
            `MCP_ADDR_FDRIVE:   rdata_nxt = {16'h0, fdrive_r};
            `MCP_ADDR_FINESSE:  rdata_nxt = {28'h0, finesse_r};
            `MCP_ADDR_OVS:      rdata_nxt = {26'h0, ovs_r};
            `MCP_ADDR_CEIL:     rdata_nxt = 32'(ceil_r[W-1:0]);
            `MCP_ADDR_BGAIN:    rdata_nxt = {16'h0, gain_r};
            default:            rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // Drive stage: pair the bands and apply the common drive
   always_comb begin
      bassIn_nxt = bassIn_r;
      midIn_nxt  = midIn_r;
      hfIn_nxt   = hfIn_r;
      if (sampleValid) begin
         bassIn_nxt = mulSat(IW'(band1) + IW'(band2), drive_r, `MCP_Q12); // [RQ2] [RQ4]
         midIn_nxt  = mulSat(IW'(band3) + IW'(band4), drive_r, `MCP_Q12); // [RQ2] [RQ4]
         hfIn_nxt   = mulSat(IW'(band5) + IW'(band6), drive_r, `MCP_Q12); // [RQ2] [RQ4]
      end
   end

   // Delay lines shift once per clipped sample
   assign bassTap[0] = bassIn_r;
   assign midTap[0]  = clampSym(midIn_r, thrAmp(midThr_r)); // [RQ6]
   assign hfTap[0]   = clampSym(hfIn_r, thrAmp(hfThr_r));   // [RQ6]
   for (genvar i = 0; i < LA; i++) begin : g_line
      assign bassTap[i+1] = bassLine_r[i];
      assign midTap[i+1]  = midLine_r[i];
      assign hfTap[i+1]   = hfLine_r[i];
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            bassLine_r[i] <= '0;
            midLine_r[i]  <= '0;
            hfLine_r[i]   <= '0;
         end else if (s1V_r) begin
            bassLine_r[i] <= bassTap[i]; // [RQ9]
            midLine_r[i]  <= midTap[i];
            hfLine_r[i]   <= hfTap[i];
         end
      end
   end

   // Band clippers, soft bass ceiling and look-ahead gain
   always_comb begin
      logic signed [IW-1:0] mhPeak;
      logic signed [IW-1:0] bPeak;
      logic signed [IW-1:0] ceil;
      logic signed [IW-1:0] bAmp;
      mhPeak    = '0;
      bPeak     = '0;
      ceil      = FSAMP;
      bAmp      = thrAmp(bassThr_r);
      bassC_nxt = bassC_r;
      midC_nxt  = midC_r;
      hfC_nxt   = hfC_r;
      gain_nxt  = gain_r;
      for (int i = 0; i <= LA; i++) begin
         if (absv(midTap[i] + hfTap[i]) > mhPeak) mhPeak = absv(midTap[i] + hfTap[i]);
         if (absv(bassTap[i]) > bPeak) bPeak = absv(bassTap[i]);
      end
      ceil = FSAMP - mhPeak;            // [RQ10] [RQ15]
      if (ceil < bAmp) ceil = bAmp;      // [RQ11] [RQ15]
      ceil_nxt = s1V_r ? ceil : ceil_r;
      if (s1V_r) begin
         if (mode_r == MCP_SOFT) begin
            // Gain follows the coming peak so the delayed bass meets the ceiling
            if (mulSat(bPeak, gain_r, `MCP_Q15) > ceil) begin
               gain_nxt = gain_r - (gain_r >> `MCP_ATTACK_SHIFT); // [RQ9]
            end else begin
               gain_nxt = gain_r + ((`MCP_GAIN_UNITY - gain_r) >> `MCP_RELEASE_SHIFT);
            end
            bassC_nxt = clampSym(mulSat(bassLine_r[LA-1], gain_r, `MCP_Q15), ceil); // [RQ9]
            midC_nxt  = midLine_r[LA-1];
            hfC_nxt   = hfLine_r[LA-1];
         end else begin
            gain_nxt  = `MCP_GAIN_UNITY;
            bassC_nxt = clampSym(bassIn_r, bAmp); // [RQ8] [RQ6]
            midC_nxt  = midTap[0];
            hfC_nxt   = hfTap[0];
         end
      end
   end

   // Post-clip filters
   mcp_post_filter #(.W(IW), .MODE(MCP_LOW), .K1(3), .K2(3)) u_bassFilt ( // [RQ3]
      .clk     (clk),
      .sys_rst (sys_rst),
      .en      (s2V_r),
      .din     (bassC_r),
      .dout    (bassF)
   );
   mcp_post_filter #(.W(IW), .MODE(MCP_BAND), .K1(1), .K2(3)) u_midFilt ( // [RQ3]
      .clk     (clk),
      .sys_rst (sys_rst),
      .en      (s2V_r),
      .din     (midC_r),
      .dout    (midF)
   );
   mcp_post_filter #(.W(IW), .MODE(MCP_HIGH), .K1(2), .K2(2)) u_hfFilt ( // [RQ3]
      .clk     (clk),
      .sys_rst (sys_rst),
      .en      (s2V_r),
      .din     (hfC_r),
      .dout    (hfF)
   );

   // Final clipper: finesse, drive, 2x oversampled clip and low-pass
   always_comb begin
      logic [IW+3:0]        red;
      mcp_gain_t            hiGain;
      logic signed [IW-1:0] mh;
      logic signed [IW-1:0] drv;
      logic signed [IW:0]   mid2;
      logic signed [IW-1:0] lvl;
      logic signed [IW-1:0] a;
      logic signed [IW-1:0] b;
      logic signed [IW-1:0] lp1;
      red       = ((IW+4)'(absv(bassF)) >> (W-16)) * (IW+4)'(finesse_r);
      red       = red >> `MCP_FINESSE_W;
      if (red > (IW+4)'(`MCP_FINESSE_MAX)) red = (IW+4)'(`MCP_FINESSE_MAX); // [RQ13]
      hiGain    = `MCP_GAIN_UNITY - red[15:0];                              // [RQ13]
      mh        = mulSat(midF + hfF, hiGain, `MCP_Q15);
      drv       = mulSat(bassF + mh, fdrive_r, `MCP_Q12);                   // [RQ12]
      mid2      = ((IW+1)'(drv) + (IW+1)'(prev_r)) >>> 1;
      lvl       = FSAMP + mulSat(FSAMP, 16'(ovs_r), `MCP_OVS_SHIFT);       // [RQ14]
      a         = clampSym(mid2[IW-1:0], lvl);                              // [RQ12]
      b         = clampSym(drv, lvl);                                       // [RQ12]
      lp1       = lp_r + ((a - lp_r) >>> `MCP_FINAL_LP_SHIFT);              // [RQ12]
      prev_nxt  = prev_r;
      lp_nxt    = lp_r;
      final_nxt = final_r;
      if (s3V_r) begin
         prev_nxt  = drv;
         lp_nxt    = lp1 + ((b - lp1) >>> `MCP_FINAL_LP_SHIFT);
         final_nxt = lp_nxt[W:0];
      end
   end

   // Registers of the path except the delay lines
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode_r    <= MCP_HARD;
         drive_r   <= `MCP_RST_DRIVE;
         bassThr_r <= `MCP_RST_THR;
         midThr_r  <= `MCP_RST_THR;
         hfThr_r   <= `MCP_RST_THR;
         fdrive_r  <= `MCP_RST_DRIVE;
         finesse_r <= '0;
         ovs_r     <= '0;
         rdata_r   <= 32'h0000_0000;
         s1V_r     <= 1'b0;
         s2V_r     <= 1'b0;
         s3V_r     <= 1'b0;
         outV_r    <= 1'b0;
         bassIn_r  <= '0;
         midIn_r   <= '0;
         hfIn_r    <= '0;
         bassC_r   <= '0;
         midC_r    <= '0;
         hfC_r     <= '0;
         ceil_r    <= FSAMP;
         gain_r    <= `MCP_GAIN_UNITY;
         prev_r    <= '0;
         lp_r      <= '0;
         final_r   <= '0;
      end else begin
         mode_r    <= mode_nxt;
         drive_r   <= drive_nxt;
         bassThr_r <= bassThr_nxt;
         midThr_r  <= midThr_nxt;
         hfThr_r   <= hfThr_nxt;
         fdrive_r  <= fdrive_nxt;
         finesse_r <= finesse_nxt;
         ovs_r     <= ovs_nxt;
         rdata_r   <= rdata_nxt;
         s1V_r     <= sampleValid;
         s2V_r     <= s1V_r;
         s3V_r     <= s2V_r;
         outV_r    <= s3V_r;
         bassIn_r  <= bassIn_nxt;
         midIn_r   <= midIn_nxt;
         hfIn_r    <= hfIn_nxt;
         bassC_r   <= bassC_nxt;
         midC_r    <= midC_nxt;
         hfC_r     <= hfC_nxt;
         ceil_r    <= ceil_nxt;
         gain_r    <= gain_nxt;
         prev_r    <= prev_nxt;
         lp_r      <= lp_nxt;
         final_r   <= final_nxt;
      end
   end

   assign regRdata = rdata_r;
   assign outValid = outV_r;
   assign finalOut = final_r;
endmodule

// ==== hdl/mcp_regs.svh ====
/*
 Register offsets, field positions, reset values and fixed shifts of the
 multiband clipper path.
 Assumes inclusion by bare name from the design files.
*/
`ifndef MCP_REGS_SVH
`define MCP_REGS_SVH

// Register offsets on the plain register port
`define MCP_ADDR_CTRL      8'h00
`define MCP_ADDR_DRIVE     8'h04
`define MCP_ADDR_BASS_THR  8'h08
`define MCP_ADDR_MID_THR   8'h0C
`define MCP_ADDR_HF_THR    8'h10
`define MCP_ADDR_FDRIVE    8'h14
`define MCP_ADDR_FINESSE   8'h18
`define MCP_ADDR_OVS       8'h1C
`define MCP_ADDR_CEIL      8'h20
`define MCP_ADDR_BGAIN     8'h24

// Field positions and widths
`define MCP_CTRL_SOFT_BIT  0
`define MCP_FINESSE_W      4
`define MCP_OVS_W          6

// Reset values and limits
`define MCP_RST_DRIVE      16'h1000
`define MCP_RST_THR        16'h4000
`define MCP_THR_MAX        16'h7FFF
`define MCP_GAIN_UNITY     16'h8000
`define MCP_FINESSE_MAX    16'h2000

// Fixed-point shifts and time constants in samples
`define MCP_Q12            12
`define MCP_Q15            15
`define MCP_OVS_SHIFT      8
`define MCP_ATTACK_SHIFT   3
`define MCP_RELEASE_SHIFT  6
`define MCP_FINAL_LP_SHIFT 1

`endif

// ==== hdl/mcp_pkg.sv ====
/*
 Types shared by the multiband clipper path files.
 Assumes nothing of its surroundings.
*/
package mcp_pkg;
   // Post-clip filter response
   typedef enum logic [1:0] {
      MCP_LOW  = 2'b00,
      MCP_BAND = 2'b01,
      MCP_HIGH = 2'b10
   } mcp_filt_e;

   // Bass clipper mode
   typedef enum logic {
      MCP_HARD = 1'b0,
      MCP_SOFT = 1'b1
   } mcp_bass_e;

   // Unsigned gain word
   typedef logic [15:0] mcp_gain_t;
endpackage

// ==== hdl/mcp_post_filter.sv ====
/*
 One post-clip filter: one-pole low-pass, high-pass as input minus
 low-pass, band-pass as a low-pass of the high-pass.
 Assumes en pulses once per sample and din holds beside it.
*/
`timescale 1ns/1ps
module mcp_post_filter #(
   parameter int                W    = 26,
   parameter mcp_pkg::mcp_filt_e MODE = mcp_pkg::MCP_LOW,
   parameter int                K1   = 2,
   parameter int                K2   = 3
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                sys_rst,
   // Sample in
   input  wire logic                en,
   input  wire logic signed [W-1:0] din,
   // Sample out
   output logic signed [W-1:0]      dout
);
   import mcp_pkg::*;

   logic signed [W-1:0] lp1_r, lp1_nxt;
   logic signed [W-1:0] lp2_r, lp2_nxt;
   logic signed [W-1:0] dout_r, dout_nxt;
   logic signed [W-1:0] hp;

   // Filter state update and response select
   always_comb begin
      lp1_nxt  = lp1_r;
      lp2_nxt  = lp2_r;
      dout_nxt = dout_r;
      hp       = din - lp1_r;
      if (en) begin
         lp1_nxt = lp1_r + ((din - lp1_r) >>> K1);
         lp2_nxt = lp2_r + ((hp - lp2_r) >>> K2);
         case (MODE)
            MCP_LOW:  dout_nxt = lp1_nxt;
            MCP_BAND: dout_nxt = lp2_nxt;
            MCP_HIGH: dout_nxt = din - lp1_nxt;
            default:  dout_nxt = din;
         endcase
      end
   end

   // Filter registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lp1_r  <= '0;
         lp2_r  <= '0;
         dout_r <= '0;
      end else begin
         lp1_r  <= lp1_nxt;
         lp2_r  <= lp2_nxt;
         dout_r <= dout_nxt;
      end
   end

   assign dout = dout_r;
endmodule

// ==== dv/mcp_path_assertions.sv ====
/*
 Checker for the multiband clipper path top ports, bound into the design.
 Assumes one clock domain and the synchronous active-high reset.
*/
`timescale 1ns/1ps
module mcp_path_assertions #(
   parameter int W  = 24,
   parameter int LA = 16
) (
   // Clock and reset
   input wire logic                clk,
   input wire logic                sys_rst,
   // Register port
   input wire logic [7:0]          regAddr,
   input wire logic [31:0]         regWdata,
   input wire logic                regWr,
   input wire logic                regRd,
   input wire logic [31:0]         regRdata,
   // Sample stream
   input wire logic                sampleValid,
   input wire logic signed [W-1:0] band1,
   input wire logic signed [W-1:0] band2,
   input wire logic signed [W-1:0] band3,
   input wire logic signed [W-1:0] band4,
   input wire logic signed [W-1:0] band5,
   input wire logic signed [W-1:0] band6,
   input wire logic                outValid,
   input wire logic signed [W:0]   finalOut
);
   localparam logic [31:0] FS  = (32'h1 << (W - 1)) - 32'h1;
   localparam longint      LEV = longint'(FS) + ((longint'(FS) * 63) >>> 8);

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Read data only after a read
   AST_RDATA_IDLE: assert property (!$past(regRd) |-> regRdata == 32'h0)
      else $error("read data out of slot");
   AST_UNMAPPED: assert property ((regRd && (regAddr > 8'h24 || regAddr[1:0] != 2'b00))
      |=> regRdata == 32'h0) else $error("unmapped read not zero");
   AST_THR_SPAN: assert property ((regRd && regAddr inside {8'h08, 8'h0C, 8'h10})
      |=> regRdata <= 32'h7FFF) else $error("threshold above full scale");
   AST_CTRL_BITS: assert property ((regRd && regAddr == 8'h00)
      |=> regRdata[31:1] == 31'h0) else $error("stray mode bits");
   AST_CEIL_SPAN: assert property ((regRd && regAddr == 8'h20)
      |=> regRdata <= FS) else $error("ceiling above full scale");
   AST_BGAIN_SPAN: assert property ((regRd && regAddr == 8'h24)
      |=> regRdata <= 32'h8000) else $error("bass gain above unity");
   // Sample pipeline timing, output hold and bound
   AST_OUT_LATENCY: assert property (sampleValid |-> ##4 outValid)
      else $error("output missing");
   AST_OUT_QUIET: assert property ((!sampleValid) [*4] |=> !outValid)
      else $error("output without a sample");
   AST_OUT_HOLD: assert property (!outValid |-> $stable(finalOut))
      else $error("output moved");
   AST_FINAL_BOUND: assert property ($signed(finalOut) <= LEV && $signed(finalOut) >= -LEV)
      else $error("output beyond clip level");

   // Main scenarios reached
   cover property (regRd && regAddr == 8'h20);
   cover property (outValid && $signed(finalOut) > 0);
   cover property (regWr && regAddr == 8'h00 && regWdata[0]);
endmodule

bind mcp_clipper_path mcp_path_assertions #(.W(W), .LA(LA)) u_chk (
   .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
   .regRd(regRd), .regRdata(regRdata), .sampleValid(sampleValid), .band1(band1),
   .band2(band2), .band3(band3), .band4(band4), .band5(band5), .band6(band6),
   .outValid(outValid), .finalOut(finalOut));

// ==== dv/mcp_band_source.sv ====
/*
 Upstream band mixer model: six band samples beside a sample strobe.
 Assumes the bench changes level and pattern only while en is low.
*/
`timescale 1ns/1ps
module mcp_band_source #(
   parameter int W = 24
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                sys_rst,
   // Control from the bench
   input  wire logic                en,
   input  wire logic                alt,
   input  wire logic [5:0]          sel,
   input  wire logic signed [W-1:0] lvl,
   // Bands toward the clipper path
   output logic                     sampleValid,
   output logic signed [W-1:0]      band1,
   output logic signed [W-1:0]      band2,
   output logic signed [W-1:0]      band3,
   output logic signed [W-1:0]      band4,
   output logic signed [W-1:0]      band5,
   output logic signed [W-1:0]      band6
);
   logic                phase;
   logic                sgn;
   logic signed [W-1:0] v;

   // One sample every second cycle, sign flips when alternating
   always_ff @(posedge clk) begin
      if (sys_rst || !en) begin
         sampleValid <= 1'b0;
         phase       <= 1'b0;
         sgn         <= 1'b0;
      end else begin
         phase       <= ~phase;
         sampleValid <= ~phase;
         if (!phase) begin
            sgn <= alt ? ~sgn : 1'b0;
         end
      end
   end

   // Live value on the strobe, scrambled between
   assign v = sampleValid ? (sgn ? -lvl : lvl) : ~lvl;
   // Six bands out, pairing into three sums is left to the path
   assign band1 = (sel[0] || !sampleValid) ? v : '0;
   assign band2 = (sel[1] || !sampleValid) ? v : '0;
   assign band3 = (sel[2] || !sampleValid) ? v : '0;
   assign band4 = (sel[3] || !sampleValid) ? v : '0;
   assign band5 = (sel[4] || !sampleValid) ? v : '0;
   assign band6 = (sel[5] || !sampleValid) ? v : '0;
endmodule

// ==== dv/tb_top.sv ====
/*
 Self-checking bench for the multiband clipper path.
 Assumes a 10 MHz clock and the band source model as upstream mixer.
*/
`timescale 1ns/1ps
module tb_top;
   localparam int          W   = 24;
   localparam logic [31:0] FS  = (32'h1 << (W - 1)) - 32'h1;
   localparam int          LEV = FS + ((FS * 63) >> 8);

   logic                clk, sys_rst, regWr, regRd, en, alt, sampleValid, outValid;
   logic [7:0]          regAddr, a;
   logic [31:0]         regWdata, regRdata, rdv, d;
   logic [5:0]          sel;
   logic signed [W-1:0] lvl, band1, band2, band3, band4, band5, band6;
   logic signed [W:0]   finalOut;
   logic signed [W+1:0] pk, lst;
   logic [31:0]         cfg [8] = '{32'h0, 32'h1000, 32'h2000, 32'h4000, 32'h4000, 32'h1000,
                                    32'h0, 32'h0};
   int                  err_total = 0, checks = 0, seed = 32'hFB94C44B, i, e, v;

   mcp_band_source #(.W(W)) u_src (.clk(clk), .sys_rst(sys_rst), .en(en), .alt(alt),
      .sel(sel), .lvl(lvl), .sampleValid(sampleValid), .band1(band1), .band2(band2),
      .band3(band3), .band4(band4), .band5(band5), .band6(band6));
   mcp_clipper_path #(.W(W), .LA(4)) uut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .sampleValid(sampleValid), .band1(band1), .band2(band2), .band3(band3),
      .band4(band4), .band5(band5), .band6(band6), .outValid(outValid), .finalOut(finalOut));

   // Expected read-back after writing d
   function automatic logic [31:0] exp_reg(input logic [7:0] ad, input logic [31:0] dd);
      case (ad)
         8'h00: exp_reg = 32'(dd[0]);
         8'h04, 8'h14: exp_reg = 32'(dd[15:0]);
         8'h08, 8'h0C, 8'h10: exp_reg = dd[15] ? 32'h7FFF : 32'(dd[15:0]);
         8'h18: exp_reg = 32'(dd[3:0]);
         8'h1C: exp_reg = 32'(dd[5:0]);
         8'h20: exp_reg = FS;
         8'h24: exp_reg = 32'h8000;
         default: exp_reg = 32'h0;
      endcase
   endfunction

   // Compare a register word
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t register read %h, expected %h", $time, got, exp);
      end
   endtask

   // Compare a level against a window, unknown fails
   task automatic chk_lvl(input logic signed [W+1:0] got, input int lo, input int hi);
      checks++;
      if ((got >= lo) && (got <= hi)) return;
      err_total++;
      $display("[FAIL] %0t level %0d outside %0d..%0d", $time, got, lo, hi);
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] dd);
      @(posedge clk);
      regWr    <= 1'b1;
      regAddr  <= ad;
      regWdata <= dd;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] ad, output logic [31:0] dd);
      @(posedge clk);
      regRd   <= 1'b1;
      regAddr <= ad;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      dd = regRdata;
   endtask

   // Stream 240 samples, keep last output and late peak
   task automatic tone(input logic [5:0] s, input int lv, input logic al);
      int n = 0, c = 0;
      pk = '0;
      @(posedge clk);
      sel <= s;
      lvl <= lv[W-1:0];
      alt <= al;
      en  <= 1'b1;
      while (n < 240 && c < 2000) begin
         @(posedge clk);
         #1;
         c++;
         if (outValid === 1'b1) begin
            n++;
            lst = finalOut;
            if (n > 160 && (lst > pk || -lst > pk)) pk = (lst < 0) ? -lst : lst;
         end
      end
      if (n < 240) begin
         err_total++;
         $display("[FAIL] %0t output strobes missing", $time);
      end
      @(posedge clk);
      en <= 1'b0;
      repeat (8) @(posedge clk);
   endtask

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Cut a hung run short
   initial begin
      #3000000;
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_sim;
   end

   initial begin
      {sys_rst, regWr, regRd, en, alt} = 5'h10;
      {regAddr, regWdata, sel, lvl} = '0;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      // Reset values and one unmapped slot
      for (i = 0; i < 11; i++) begin
         d = (i == 1 || i == 5) ? 32'h1000 : (i >= 2 && i <= 4) ? 32'h4000 : 32'h0;
         rd(8'(i * 4), rdv);
         chk_reg(rdv, exp_reg(8'(i * 4), d));
      end
      // Random writes to the eleven slots, read straight back
      for (i = 0; i < 16; i++) begin
         a = 8'(({$random(seed)} % 11) * 4);
         d = $random(seed);
         wr(a, d);
         rd(a, rdv);
         chk_reg(rdv, exp_reg(a, d));
      end
      for (i = 0; i < 8; i++) wr(8'(i * 4), cfg[i]);
      // Each band alone: DC, then alternating
      for (i = 0; i < 6; i++) begin
         e = (i < 2) ? 32'h180000 : 0;
         tone(6'(1 << i), 32'h180000, 1'b0);
         chk_lvl(lst, e - 48, e + 48);
         tone(6'(1 << i), 32'h100000, 1'b1);
         if (i >= 4) chk_lvl(pk, 32'h20000, FS);
         else chk_lvl(pk, 0, 32'h20000);
      end
      // Paired bands sum above the bass threshold
      tone(6'b000011, 32'h180000, 1'b0);
      chk_lvl(lst, 32'h200000 - 48, 32'h200000);
      // Doubled drive, random level
      wr(8'h08, 32'h7FFF);
      wr(8'h04, 32'h2000);
      v = 32'h40000 + {$random(seed)} % 32'hC0000;
      tone(6'b000001, v, 1'b0);
      chk_lvl(lst, 2 * v - 48, 2 * v);
      wr(8'h04, 32'h1000);
      wr(8'h08, 32'h2000);
      // Final drive of eight hits clip level, then raised one
      wr(8'h14, 32'h8000);
      tone(6'b000001, 32'h300000, 1'b0);
      chk_lvl(lst, FS - 48, FS);
      wr(8'h1C, 32'h3F);
      tone(6'b000001, 32'h300000, 1'b0);
      chk_lvl(lst, LEV - 48, LEV);
      wr(8'h14, 32'h1000);
      wr(8'h1C, 32'h0);
      // Soft bass alone rises past threshold
      wr(8'h00, 32'h1);
      tone(6'b000001, 32'h600000, 1'b0);
      chk_lvl(lst, 32'h600000 - 48, 32'h600000);
      rd(8'h20, rdv);
      chk_reg(rdv, FS);
      // Mid lowers the ceiling, mid plus high reach the floor
      for (i = 0; i < 2; i++) begin
         e = (i == 1) ? 32'h200000 : FS - 32'h400000;
         tone({i[0], 5'b00101}, FS, 1'b0);
         chk_lvl(lst, e * 3 / 4, e + 48);
         rd(8'h20, rdv);
         chk_reg(rdv, e);
      end
      // Reset in mid-run returns hard mode
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'h00, rdv);
      chk_reg(rdv, 32'h0);
      end_sim;
   end
endmodule
